// file: include/adcsnc_defines.vh
/*
  Constants for the converter selection and noise-canceler control block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef ADCSNC_DEFINES_VH
`define ADCSNC_DEFINES_VH

// ----------------------------------------------------------------
// Register word addresses (Avalon word address, byte address / 4)
// ----------------------------------------------------------------
`define ADCSNC_ADDR_W 2
`define ADCSNC_A_SEL 2'h0
`define ADCSNC_A_CTRL 2'h1
`define ADCSNC_A_STAT 2'h2
`define ADCSNC_A_RES 2'h3

// ----------------------------------------------------------------
// Selection register fields
// ----------------------------------------------------------------
`define ADCSNC_CH_LSB 0
`define ADCSNC_CH_MSB 4
`define ADCSNC_REF_LSB 6
`define ADCSNC_REF_MSB 7
`define ADCSNC_SEL_W 7

// Reference choices
`define ADCSNC_REF_EXT 2'h0
`define ADCSNC_REF_SUPPLY 2'h1
`define ADCSNC_REF_INT 2'h3
`define ADCSNC_REF_RSVD 2'h2

// ----------------------------------------------------------------
// Control register bits
// ----------------------------------------------------------------
`define ADCSNC_C_EN 0
`define ADCSNC_C_START 1
`define ADCSNC_C_FREE 2
`define ADCSNC_C_IE 3
`define ADCSNC_C_DONE 4
`define ADCSNC_C_PS_LSB 8
`define ADCSNC_C_PS_MSB 15

// Status register bits
`define ADCSNC_S_BUSY 0
`define ADCSNC_S_FIRST 1
`define ADCSNC_S_JTAG 2
`define ADCSNC_S_ASEL_LSB 8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ADCSNC_CYC_NORMAL 5'h0D
`define ADCSNC_CYC_FIRST 5'h19
`define ADCSNC_PS_DEFAULT 8'h3F
`define ADCSNC_FULL_SCALE 10'h3FF

`endif

// file: hw/adcsnc_sync.v
/*
  Two-stage level synchroniser, parameterised width.
  Assumes the input comes from outside the clk_i domain.
*/
`timescale 1ns/10ps
`default_nettype none

module adcsnc_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire clk_i,
  input wire resetn_i,
  // Data
  input wire [WIDTH-1:0] d_i,
  output reg [WIDTH-1:0] q_o
);

  reg [WIDTH-1:0] meta_reg;

  // First stage read only by the second
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg <= {WIDTH{1'b0}};
      q_o <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// file: hw/adcsnc_top.v
/*
  Converter control: buffered channel/reference selection with lock during
  conversion, conversion timing on a prescaled converter clock tick, and the
  sleep-started noise-canceler conversion.
  Assumes an Avalon-MM master on clk_i, pins sleep/jtag/sample from outside.
*/
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "adcsnc_defines.vh"

// Function
// - CPU-writable buffer holds channel and reference
// - Idle: buffer copied to active every cycle
// - Conversion running: active selection frozen
// - Copy resumes in last converter cycle
// - Start waits for next converter clock edge
// - JTAG overrides upper four port pins
// - Three reference choices offered
// - Over-range single-ended input gives full scale
// - Sleep with converter ready starts conversion
// - Completion interrupt wakes CPU from sleep
// - Completion interrupt raised even when woken early
// - Other sleep modes leave converter enabled
// - Selection applied only while converter enabled
// - Conversions take 13 cycles, first 25
module adcsnc_top #(
  parameter PS_W = 8
) (
  // Clock and reset
  input wire clk_i,
  input wire resetn_i,
  // Avalon-MM slave
  input wire [`ADCSNC_ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  // Power manager (asynchronous)
  input wire sleep_nr_i,
  input wire sleep_idle_i,
  input wire jtag_en_i,
  // Analog side
  input wire [9:0] sample_i,
  input wire over_range_i,
  output reg [4:0] active_channel_o,
  output reg [1:0] active_reference_o,
  output reg converter_on_o,
  output reg sample_hold_o,
  output reg [3:0] upper_port_adc_en_o,
  // Interrupt request
  output reg irq_o
);

  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_CONV = 3'b100;

  reg [`ADCSNC_SEL_W:0] sel_buf_reg;
  reg en_reg;
  reg start_reg;
  reg free_reg;
  reg ie_reg;
  reg done_reg;
  reg first_reg;
  reg [PS_W-1:0] ps_reg;
  reg [PS_W-1:0] ps_cnt_reg;
  reg tick_reg;
  reg [2:0] state_reg;
  reg [4:0] cyc_reg;
  reg [4:0] len_reg;
  reg [9:0] result_reg;
  reg sleep_armed_reg;
  reg ack_reg;
  wire [7:0] sel_sync;
  wire [3:0] pin_sync;
  wire sync_nr;
  wire sync_idle;
  wire sync_jtag;
  wire sync_over;
  wire [9:0] sample_sync;
  wire last_cycle;
  wire complete;
  wire sleep_req;
  wire wr;

  // Return the reference code with the reserved code forced to external
  function [1:0] ref_legal;
    input [1:0] r;
    begin
      if (r == `ADCSNC_REF_RSVD) begin
        ref_legal = `ADCSNC_REF_EXT;
      end else begin
        ref_legal = r;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // buffer crosses by synchroniser
  adcsnc_sync #(.WIDTH(8)) u_sel_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(sel_buf_reg),
    .q_o(sel_sync)
  );

  adcsnc_sync #(.WIDTH(4)) u_pin_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i({sleep_nr_i, sleep_idle_i, jtag_en_i, over_range_i}),
    .q_o(pin_sync)
  );

  adcsnc_sync #(.WIDTH(10)) u_smp_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(sample_i),
    .q_o(sample_sync)
  );

  assign sync_nr = pin_sync[3];
  assign sync_idle = pin_sync[2];
  assign sync_jtag = pin_sync[1];
  assign sync_over = pin_sync[0];
  assign wr = avs_write_i && !avs_waitrequest_o;
  assign last_cycle = (state_reg == ST_CONV) && (cyc_reg == len_reg - 5'h01);
  assign complete = last_cycle && tick_reg;
  assign sleep_req = (sync_nr || sync_idle) && en_reg && !start_reg && !free_reg && ie_reg;

  // ----------------------------------------------------------------
  // Avalon slave: one wait state, then answer
  // ----------------------------------------------------------------
  // Waitrequest drops one cycle after request, for one cycle
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_reg <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else begin
      ack_reg <= (avs_read_i || avs_write_i) && !ack_reg && avs_waitrequest_o;
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_reg && avs_waitrequest_o);
    end
  end

  // Read data captured when a read is taken, held until the next one
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && !ack_reg && avs_waitrequest_o) begin
      case (avs_address_i)
        `ADCSNC_A_SEL: avs_readdata_o <= {24'h000000, sel_buf_reg};
        `ADCSNC_A_CTRL: avs_readdata_o <= {16'h0000, ps_reg, 3'h0, done_reg, ie_reg,
                                            free_reg, start_reg, en_reg};
        `ADCSNC_A_STAT: avs_readdata_o <= {17'h00000, active_reference_o,
                                            active_channel_o, 5'h00, sync_jtag, first_reg,
                                            state_reg != ST_IDLE};
        `ADCSNC_A_RES: avs_readdata_o <= {22'h000000, result_reg};
        default: avs_readdata_o <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Selection buffer and control bits
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_buf_reg <= 8'h00;
      en_reg <= 1'b0;
      free_reg <= 1'b0;
      ie_reg <= 1'b0;
      ps_reg <= `ADCSNC_PS_DEFAULT;
    end else if (wr && avs_address_i == `ADCSNC_A_SEL) begin
      sel_buf_reg <= avs_writedata_i[7:0];
    end else if (wr && avs_address_i == `ADCSNC_A_CTRL) begin
      en_reg <= avs_writedata_i[`ADCSNC_C_EN];
      free_reg <= avs_writedata_i[`ADCSNC_C_FREE];
      ie_reg <= avs_writedata_i[`ADCSNC_C_IE];
      ps_reg <= avs_writedata_i[`ADCSNC_C_PS_MSB:`ADCSNC_C_PS_LSB];
    end
  end

  // Start bit: set by write or sleep, cleared on single completion
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      start_reg <= 1'b0;
    end else if (!en_reg) begin
      start_reg <= 1'b0;
    end else if ((wr && avs_address_i == `ADCSNC_A_CTRL && avs_writedata_i[`ADCSNC_C_START])
                 || (sleep_req && !sleep_armed_reg)) begin
      start_reg <= 1'b1;
    end else if (complete && !free_reg) begin
      start_reg <= 1'b0;
    end
  end

  // Sleep arm: one start per sleep entry
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sleep_armed_reg <= 1'b0;
    end else begin
      sleep_armed_reg <= sync_nr || sync_idle;
    end
  end

  // Done flag: set wins over write-one clear
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done_reg <= 1'b0;
    end else if (complete) begin
      done_reg <= 1'b1;
    end else if (wr && avs_address_i == `ADCSNC_A_CTRL && avs_writedata_i[`ADCSNC_C_DONE]) begin
      done_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler: converter clock tick
  // ----------------------------------------------------------------
  // Counter held reset while disabled
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ps_cnt_reg <= {PS_W{1'b0}};
      tick_reg <= 1'b0;
    end else if (!en_reg) begin
      ps_cnt_reg <= {PS_W{1'b0}};
      tick_reg <= 1'b0;
    end else if (ps_cnt_reg >= ps_reg) begin
      ps_cnt_reg <= {PS_W{1'b0}};
      tick_reg <= 1'b1;
    end else begin
      ps_cnt_reg <= ps_cnt_reg + {{(PS_W-1){1'b0}}, 1'b1};
      tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  // State, cycle count and result
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
      cyc_reg <= 5'h00;
      len_reg <= `ADCSNC_CYC_NORMAL;
      first_reg <= 1'b1;
      result_reg <= 10'h000;
      sample_hold_o <= 1'b0;
    end else if (!en_reg) begin
      state_reg <= ST_IDLE;
      first_reg <= 1'b1;
      sample_hold_o <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_reg) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (tick_reg) begin
            state_reg <= ST_CONV;
            cyc_reg <= 5'h00;
            len_reg <= first_reg ? `ADCSNC_CYC_FIRST : `ADCSNC_CYC_NORMAL;
            first_reg <= 1'b0;
            sample_hold_o <= 1'b1;
          end
        end
        ST_CONV: begin
          if (tick_reg) begin
            cyc_reg <= cyc_reg + 5'h01;
            sample_hold_o <= 1'b0;
            if (complete) begin
              result_reg <= sync_over ? `ADCSNC_FULL_SCALE : sample_sync;
              if (free_reg) begin
                state_reg <= ST_CONV;
                cyc_reg <= 5'h00;
                len_reg <= `ADCSNC_CYC_NORMAL;
                sample_hold_o <= 1'b1;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Active selection
  // ----------------------------------------------------------------
  // Copy buffer while enabled outside conversion or in last cycle, else hold
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      active_channel_o <= 5'h00;
      active_reference_o <= `ADCSNC_REF_EXT;
    end else if (en_reg && (state_reg != ST_CONV || last_cycle)) begin
      active_channel_o <= sel_sync[`ADCSNC_CH_MSB:`ADCSNC_CH_LSB];
      active_reference_o <= ref_legal(sel_sync[`ADCSNC_REF_MSB:`ADCSNC_REF_LSB]);
    end
  end

  // Converter power, pin override and interrupt
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      converter_on_o <= 1'b0;
      upper_port_adc_en_o <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      converter_on_o <= en_reg;
      upper_port_adc_en_o <= sync_jtag ? 4'h0 : {4{en_reg}};
      irq_o <= (done_reg || complete) && ie_reg;
    end
  end

endmodule

`default_nettype wire

// file: tb/adcsnc_properties.sv
/*
  Checker for adcsnc_top: bus handshake, selection lock, pin override.
  Assumes it is bound to adcsnc_top and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none

module adcsnc_properties #(
  parameter PS_W = 8
) (
  // Clock and reset
  input wire clk_i,
  input wire resetn_i,
  // Bus
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  // Pins
  input wire jtag_en_i,
  input wire [4:0] active_channel_o,
  input wire [1:0] active_reference_o,
  input wire converter_on_o,
  input wire sample_hold_o,
  input wire [3:0] upper_port_adc_en_o,
  input wire irq_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // Answer comes within two edges, lasts one cycle
  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |-> ##[0:2] !avs_waitrequest_o) else $error("bus request not answered");
  a_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  // Read data hold between requests
  a_rdata_hold: assert property (avs_waitrequest_o && $past(avs_waitrequest_o)
    && !avs_read_i && !avs_write_i |-> $stable(avs_readdata_o))
    else $error("read data changed while idle");
  a_jtag_override: assert property (jtag_en_i [*4] |-> upper_port_adc_en_o == 4'h0)
    else $error("port pins not overridden");
  a_ref_code: assert property (active_reference_o != 2'h2)
    else $error("reserved reference applied");
  a_sel_frozen: assert property (sample_hold_o && $past(sample_hold_o)
    |-> $stable(active_reference_o) && $stable(active_channel_o))
    else $error("selection moved while sampling");
  a_hold_off: assert property (!converter_on_o && !$past(converter_on_o)
    |-> !sample_hold_o) else $error("sampling while converter off");
  a_off_ports: assert property (!converter_on_o && !$past(converter_on_o)
    |-> upper_port_adc_en_o == 4'h0) else $error("port pins on while off");

  // Main scenarios
  c_hold: cover property ($rose(sample_hold_o));
  c_irq: cover property ($rose(irq_o));
  c_jtag: cover property (jtag_en_i && converter_on_o);
  c_read: cover property (avs_read_i && !avs_waitrequest_o);
endmodule

bind adcsnc_top adcsnc_properties #(.PS_W(PS_W)) i_adcsnc_properties (
  .clk_i(clk_i), .resetn_i(resetn_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .jtag_en_i(jtag_en_i),
  .active_channel_o(active_channel_o),
  .active_reference_o(active_reference_o), .converter_on_o(converter_on_o),
  .sample_hold_o(sample_hold_o), .upper_port_adc_en_o(upper_port_adc_en_o),
  .irq_o(irq_o));

`default_nettype wire

// file: tb/adcsnc_top_tb.sv
/*
  Bench for adcsnc_top: bus tasks and test sequences.
  Assumes the design and the checker are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none

module adcsnc_top_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [1:0] avs_address_i = 2'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic sleep_nr_i = 1'b0;
  logic sleep_idle_i = 1'b0;
  logic jtag_en_i = 1'b0;
  logic [9:0] sample_i = 10'h2A5;
  logic over_range_i = 1'b0;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o;
  wire [4:0] active_channel_o;
  wire [1:0] active_reference_o;
  wire converter_on_o;
  wire sample_hold_o;
  wire [3:0] upper_port_adc_en_o;
  wire irq_o;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0;
  int n;
  logic [31:0] rd_v;

  // Clock and cycle ceiling
  initial forever #25 clk_i = ~clk_i;
  initial forever begin
    @(posedge clk_i);
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      results();
    end
  end

  adcsnc_top i_adcsnc_top (
    .clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .sleep_nr_i(sleep_nr_i),
    .sleep_idle_i(sleep_idle_i), .jtag_en_i(jtag_en_i), .sample_i(sample_i),
    .over_range_i(over_range_i), .active_channel_o(active_channel_o),
    .active_reference_o(active_reference_o), .converter_on_o(converter_on_o),
    .sample_hold_o(sample_hold_o), .upper_port_adc_en_o(upper_port_adc_en_o),
    .irq_o(irq_o));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic [1:0] a, input logic wr, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
    rd_v = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Wait for sampling, return its width in clocks
  task automatic wait_hold(output int w);
    int k;
    k = 0;
    w = 0;
    while (sample_hold_o !== 1'b1 && k < 200) begin
      @(posedge clk_i);
      k++;
    end
    while (sample_hold_o === 1'b1 && w < 200) begin
      @(posedge clk_i);
      w++;
    end
  endtask

  task automatic wait_irq();
    int k;
    k = 0;
    while (irq_o !== 1'b1 && k < 300) begin
      @(posedge clk_i);
      k++;
    end
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    bus(2'h1, 1'b0, 32'h0);
    chk("ctrl_rst", rd_v, 32'h00003F00);
    bus(2'h0, 1'b1, 32'h55);
    repeat (6) @(posedge clk_i);
    chk("ch_off", active_channel_o, 5'h00);
    bus(2'h1, 1'b1, 32'h309);
    repeat (6) @(posedge clk_i);
    chk("ch_on", active_channel_o, 5'h15);
    chk("port_on", upper_port_adc_en_o, 4'hF);
    jtag_en_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("port_jtag", upper_port_adc_en_o, 4'h0);
    jtag_en_i <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      bus(2'h0, 1'b1, {24'h0, r[1:0], 6'h15});
      repeat (6) @(posedge clk_i);
      chk("ref", active_reference_o, (r == 2) ? 2'h0 : r[1:0]);
    end
    $display("test selection done");
    repeat (2500) @(posedge clk_i);
    bus(2'h1, 1'b1, 32'h30B);
    t0 = cyc;
    wait_hold(n);
    chk("hold_w", n, 4);
    bus(2'h0, 1'b1, 32'h47);
    repeat (6) @(posedge clk_i);
    chk("ch_lock", active_channel_o, 5'h15);
    wait_irq();
    chk("t_first", (cyc - t0 >= 96) && (cyc - t0 <= 112), 1);
    chk("ch_after", active_channel_o, 5'h07);
    bus(2'h2, 1'b0, 32'h0);
    chk("stat", rd_v, 32'h00002700);
    // first result after reference switch checked as data path only
    bus(2'h3, 1'b0, 32'h0);
    chk("res", rd_v, 32'h2A5);
    bus(2'h1, 1'b0, 32'h0);
    chk("ctrl_done", rd_v & 32'h12, 32'h10);
    over_range_i <= 1'b1;
    bus(2'h1, 1'b1, 32'h31B);
    t0 = cyc;
    repeat (2) @(posedge clk_i);
    wait_irq();
    chk("t_norm", (cyc - t0 >= 48) && (cyc - t0 <= 64), 1);
    bus(2'h3, 1'b0, 32'h0);
    chk("res_full", rd_v, 32'h3FF);
    over_range_i <= 1'b0;
    $display("test conversion done");
    for (int s = 0; s < 2; s++) begin
      bus(2'h1, 1'b1, 32'h319);
      repeat (4) @(posedge clk_i);
      chk("irq_clr", irq_o, 1'b0);
      if (s == 0) sleep_nr_i <= 1'b1;
      else sleep_idle_i <= 1'b1;
      wait_hold(n);
      if (s == 1) sleep_idle_i <= 1'b0;
      wait_irq();
      chk("irq_sleep", irq_o, 1'b1);
      sleep_nr_i <= 1'b0;
      @(posedge clk_i);
    end
    $display("test sleep done");
    bus(2'h1, 1'b1, 32'h0);
    repeat (4) @(posedge clk_i);
    chk("conv_off", converter_on_o, 1'b0);
    chk("port_off", upper_port_adc_en_o, 4'h0);
    $display("test disable done");
    results();
  end
endmodule

`default_nettype wire
